// ==== stream_pkg.sv ====
// shared constants and carrier types for the streaming source controller
package stream_pkg;
   // bits per symbol, default 8, legal 1 to 512
   localparam int bits_per_symbol_param = 8;
   // symbols carried in one transfer
   localparam int symbols_per_transfer_param = 4;
   // data width, must stay within 1 to 256
   localparam int data_width = bits_per_symbol_param * symbols_per_transfer_param;
   // channel field width, 0 to 8 allowed
   localparam int channel_width = 8;
   // highest channel number the link supports, up to 255
   localparam logic [7:0] highest_channel_param = 8'hFF;
   // error mask width, 1 to 255
   localparam int error_width = 2;
   // error bit meanings, first entry is the top bit: bit 1 crc, bit 0 overflow
   localparam int fault_crc_bit = 1;
   localparam int fault_overflow_bit = 0;
   // unused-symbol count width, log2 of symbols per transfer
   localparam int empty_width = 2;
   // accept delay, default 0, legal 0 to 8
   localparam int accept_delay_cycles = 0;
   // history depth of the ready pipeline, at least two stages
   localparam int ready_hist_depth = 9;
   // reset value of the in-packet, user ready and packet error flags
   localparam logic reset_level = 1'b0;

   // one transfer as driven toward the sink
   typedef struct packed {
      logic valid;
      logic [data_width-1:0] data;
      logic [channel_width-1:0] channel;
      logic [error_width-1:0] error;
      logic startofpacket;
      logic endofpacket;
      logic [empty_width-1:0] empty;
   } beat_t;

   // one beat as the user offers it
   typedef struct packed {
      logic [data_width-1:0] data;
      logic [channel_width-1:0] channel;
      logic [error_width-1:0] error;
      logic startofpacket;
      logic endofpacket;
      logic [empty_width-1:0] empty;
   } user_beat_t;
endpackage

// ==== ready_sync.sv ====
// ready delay line that turns sink ready into ready cycles; ready shares our clock, so no sync stages
module ready_sync
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // raw ready from the sink
   input wire logic ready_in,
   // ready cycle marker for the current cycle
   output logic ready_cycle_out
);
   // ready history; stage 0 is the ready seen one cycle back
   logic [stream_pkg::ready_hist_depth-1:0] hist_reg;

   // shift ready into the history each cycle
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         hist_reg <= '0;
      end
      else
      begin
         hist_reg <= {hist_reg[stream_pkg::ready_hist_depth-2:0], ready_in};
      end
   end

   // zero delay uses ready of this very cycle, otherwise ready from n cycles back
   generate
      if (stream_pkg::accept_delay_cycles == 0)
      begin : g_zero
         assign ready_cycle_out = ready_in;
      end
      else
      begin : g_delay
         assign ready_cycle_out = hist_reg[stream_pkg::accept_delay_cycles-1];
      end
   endgenerate
endmodule // ready_sync

// ==== beat_hold.sv ====
// one-entry holding register for a user beat waiting to be launched
module beat_hold
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // write side
   input wire logic wr_en_in,
   input wire stream_pkg::user_beat_t wr_beat_in,
   // registered read data
   output stream_pkg::user_beat_t rd_beat_out
);
   // held beat
   stream_pkg::user_beat_t beat_reg;

   // load on write, else keep
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         beat_reg <= '0;
      end
      else if (wr_en_in)
      begin
         beat_reg <= wr_beat_in;
      end
   end

   assign rd_beat_out = beat_reg;
endmodule // beat_hold

// ==== stream_source.sv ====
// streaming source controller: takes user beats and drives them to a sink
module stream_source
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // user side: offered beat
   input wire logic user_valid_in,
   input wire stream_pkg::user_beat_t user_beat_in,
   output logic user_ready_out,
   // user side: status
   output logic busy_out,
   output logic [15:0] beat_count_out,
   output logic packet_error_out,
   // streaming side toward the sink
   input wire logic ready_in,
   output logic valid_out,
   output logic [stream_pkg::data_width-1:0] data_out,
   output logic [stream_pkg::channel_width-1:0] channel_out,
   output logic [stream_pkg::error_width-1:0] error_out,
   output logic startofpacket_out,
   output logic endofpacket_out,
   output logic [stream_pkg::empty_width-1:0] empty_out
);
   // launch state machine
   typedef enum logic [1:0]
   {
      st_idle = 2'b00,
      st_hold = 2'b01,
      st_send = 2'b10
   } state_t;

   // current and next state
   state_t state_reg;
   state_t state_next;
   // beat now on the wires
   stream_pkg::beat_t out_reg;
   stream_pkg::beat_t out_next;
   // held user beat from the hold module
   stream_pkg::user_beat_t held_beat;
   // ready cycle marker derived from ready
   logic ready_cycle;
   // transfer completes this cycle
   logic beat_taken;
   // hold register load strobe
   logic hold_load;
   // inside a packet, used to flag marker misuse
   logic in_packet_reg;
   logic in_packet_next;
   // counters and flags kept for status
   logic [15:0] count_reg;
   logic error_reg;
   logic user_ready_reg;

   // clamp a channel to the declared highest value
   function automatic logic [stream_pkg::channel_width-1:0] clamp_channel
   (
      input logic [stream_pkg::channel_width-1:0] ch
   );
      clamp_channel = (ch > stream_pkg::highest_channel_param) ? stream_pkg::highest_channel_param : ch;
   endfunction

   // force the empty count to zero on beats without end marker
   function automatic logic [stream_pkg::empty_width-1:0] clean_empty
   (
      input logic eop,
      input logic [stream_pkg::empty_width-1:0] emp
   );
      clean_empty = eop ? emp : '0;
   endfunction

   // ready delay line; ready comes from logic on the same clock, so no sync stages
   ready_sync u_ready_sync
   (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .ready_in(ready_in),
      .ready_cycle_out(ready_cycle)
   );

   // one-entry hold for a beat accepted while the wires are busy
   beat_hold u_beat_hold
   (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(hold_load),
      .wr_beat_in(user_beat_in),
      .rd_beat_out(held_beat)
   );

   // a beat counts as moved only when valid meets a ready cycle
   assign beat_taken = out_reg.valid & ready_cycle;
   // user beat is accepted when user_ready_reg is high
   assign hold_load = user_valid_in & user_ready_reg & (state_reg == st_send) & ~beat_taken;

   // next-state and next-beat logic
   always_comb
   begin
      state_next = state_reg;
      out_next = out_reg;
      in_packet_next = in_packet_reg;
      case (state_reg)
         st_idle:
         begin
            // nothing on the wires
            out_next.valid = 1'b0;
            if (user_valid_in && user_ready_reg && (stream_pkg::accept_delay_cycles == 0 || ready_cycle))
            begin
               // with delay the beat is launched only inside a ready cycle window
               out_next = {1'b1, user_beat_in.data, clamp_channel(user_beat_in.channel), user_beat_in.error,
                  user_beat_in.startofpacket, user_beat_in.endofpacket,
                  clean_empty(user_beat_in.endofpacket, user_beat_in.empty)};
               state_next = st_send;
            end
         end
         st_send:
         begin
            if (stream_pkg::accept_delay_cycles == 0)
            begin
               // zero delay: hold valid and data until ready arrives
               if (beat_taken)
               begin
                  out_next.valid = 1'b0;
                  state_next = st_idle;
                  if (user_valid_in && user_ready_reg)
                  begin
                     // back-to-back launch of the next user beat
                     out_next = {1'b1, user_beat_in.data, clamp_channel(user_beat_in.channel), user_beat_in.error,
                        user_beat_in.startofpacket, user_beat_in.endofpacket,
                        clean_empty(user_beat_in.endofpacket, user_beat_in.empty)};
                     state_next = st_send;
                  end
                  else if (hold_load)
                  begin
                     state_next = st_hold;
                  end
               end
               else if (hold_load)
               begin
                  state_next = st_hold;
               end
            end
            else
            begin
               // nonzero delay: valid lasts one ready cycle only, then drops
               out_next.valid = 1'b0;
               state_next = hold_load ? st_hold : st_idle;
            end
         end
         st_hold:
         begin
            // a held beat waits for the wires to free up
            if (!out_reg.valid && (stream_pkg::accept_delay_cycles == 0 || ready_cycle))
            begin
               out_next = {1'b1, held_beat.data, clamp_channel(held_beat.channel), held_beat.error,
                  held_beat.startofpacket, held_beat.endofpacket,
                  clean_empty(held_beat.endofpacket, held_beat.empty)};
               state_next = st_send;
            end
            else if (beat_taken)
            begin
               out_next.valid = 1'b0;
            end
            else if (stream_pkg::accept_delay_cycles != 0)
            begin
               // outside ready cycles valid must stay low
               out_next.valid = 1'b0;
            end
         end
         default:
         begin
            out_next.valid = 1'b0;
            state_next = st_idle;
         end
      endcase
      // packet tracking on each taken beat
      if (beat_taken)
      begin
         if (out_reg.startofpacket)
         begin
            in_packet_next = 1'b1;
         end
         if (out_reg.endofpacket)
         begin
            in_packet_next = 1'b0;
         end
      end
   end

   // state, outputs and in-packet flag; every stream output is a flop
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= st_idle;
         out_reg <= '0;
         in_packet_reg <= stream_pkg::reset_level;
      end
      else
      begin
         state_reg <= state_next;
         out_reg <= out_next;
         in_packet_reg <= in_packet_next;
      end
   end

   // user ready: free unless a beat is already held
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         user_ready_reg <= stream_pkg::reset_level;
      end
      else
      begin
         user_ready_reg <= (state_next != st_hold);
      end
   end

   // count of taken beats, wraps silently
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         count_reg <= 16'h0000;
      end
      else if (beat_taken)
      begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // sticky flag for start-without-end or end-without-start misuse by the user
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         error_reg <= stream_pkg::reset_level;
      end
      else if (beat_taken && ((out_reg.startofpacket && in_packet_reg) ||
         (!out_reg.startofpacket && !in_packet_reg && out_reg.endofpacket)))
      begin
         error_reg <= 1'b1;
      end
   end

   // drive ports from the registers
   assign valid_out = out_reg.valid;
   assign data_out = out_reg.data;
   assign channel_out = out_reg.channel;
   assign error_out = out_reg.error;
   assign startofpacket_out = out_reg.startofpacket;
   assign endofpacket_out = out_reg.endofpacket;
   assign empty_out = out_reg.empty;
   assign user_ready_out = user_ready_reg;
   assign busy_out = out_reg.valid;
   assign beat_count_out = count_reg;
   assign packet_error_out = error_reg;
endmodule // stream_source

// ==== stream_source_sva.sv ====
// concurrent checks on the streaming source controller ports
module stream_source_sva
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // user side
   input wire logic user_valid_in,
   input wire stream_pkg::user_beat_t user_beat_in,
   input wire logic user_ready_out,
   input wire logic [15:0] beat_count_out,
   input wire logic packet_error_out,
   // stream side
   input wire logic ready_in,
   input wire logic valid_out,
   input wire logic [stream_pkg::data_width-1:0] data_out,
   input wire logic [stream_pkg::channel_width-1:0] channel_out,
   input wire logic startofpacket_out,
   input wire logic endofpacket_out,
   input wire logic [stream_pkg::empty_width-1:0] empty_out
);
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   wire take = valid_out && ready_in; // a beat crosses on this edge
   logic in_pkt_reg; // a packet is open on the wire
   // track framing as the sink sees it, so misuse can be tied to the fault flag
   always_ff @(posedge core_clk_in or negedge rst_n_in)
      if (!rst_n_in)
         in_pkt_reg <= 1'b0;
      else if (take)
         in_pkt_reg <= startofpacket_out ? !endofpacket_out : (in_pkt_reg && !endofpacket_out);
   stall_hold_a: assert property (valid_out && !ready_in |=> valid_out && $stable(data_out) && $stable(channel_out))
      else $error("stalled beat changed");
   count_step_a: assert property (take |=> beat_count_out == $past(beat_count_out) + 16'h1)
      else $error("taken beat not counted");
   count_hold_a: assert property (!take |=> $stable(beat_count_out))
      else $error("count moved without a transfer");
   empty_zero_a: assert property (valid_out && !endofpacket_out |-> empty_out == '0)
      else $error("empty set off an end beat");
   launch_a: assert property (user_valid_in && user_ready_out |=> valid_out)
      else $error("taken user beat not launched");
   load_data_a: assert property (user_valid_in && user_ready_out && !valid_out |=> data_out == $past(user_beat_in.data))
      else $error("launched data differs");
   sop_fault_a: assert property (take && startofpacket_out && in_pkt_reg |=> packet_error_out)
      else $error("start inside packet not flagged");
   eop_fault_a: assert property (take && endofpacket_out && !startofpacket_out && !in_pkt_reg |=> packet_error_out)
      else $error("end outside packet not flagged");
   fault_sticky_a: assert property (packet_error_out |=> packet_error_out)
      else $error("framing fault cleared");
endmodule // stream_source_sva

bind stream_source stream_source_sva chk (.core_clk_in, .rst_n_in, .user_valid_in, .user_beat_in, .user_ready_out,
   .beat_count_out, .packet_error_out, .ready_in, .valid_out, .data_out, .channel_out, .startofpacket_out,
   .endofpacket_out, .empty_out);

// ==== stream_sink_model.sv ====
// behavioural sink with selectable backpressure
module stream_sink_model
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // 0 always ready, 1 never ready, 2 every other cycle
   input wire logic [1:0] mode_in,
   // beat in, backpressure out
   input wire stream_pkg::beat_t beat_in,
   output logic ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   stream_pkg::beat_t got[$]; // accepted beats, oldest first
   stream_pkg::beat_t b; // beat as sampled
   // ready moves just after the edge; zero delay makes it mark this same cycle
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         ready_out <= 1'b0;
      else
         ready_out <= (mode_in == 2'h0) || (mode_in == 2'h2 && !ready_out);
   end
   // take only valid beats on ready cycles, ignore everything else
   always @(posedge core_clk_in)
   begin
      b = beat_in;
      if (!b.endofpacket)
         b.empty = '0; // meaningless off an end beat
      if (rst_n_in && b.valid && ready_out)
         got.push_back(b);
   end
endmodule // stream_sink_model

// ==== stream_source_bench.sv ====
// self-checking bench for the streaming source controller
module stream_source_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic user_valid_in = 1'b0;
   stream_pkg::user_beat_t user_beat_in = '0;
   logic [1:0] mode = 2'h0;
   logic ready_in, user_ready_out, busy_out, packet_error_out, valid_out, startofpacket_out, endofpacket_out;
   logic [15:0] beat_count_out;
   logic [31:0] data_out;
   logic [7:0] channel_out;
   logic [1:0] error_out, empty_out;
   stream_pkg::beat_t sb; // stream side seen as one beat
   stream_pkg::user_beat_t e[4]; // beats of the current scenario
   int n_fail = 0;
   int checked = 0;
   assign sb = {valid_out, data_out, channel_out, error_out, startofpacket_out, endofpacket_out, empty_out};
   always #20 core_clk_in = ~core_clk_in;
   stream_source dut (.core_clk_in, .rst_n_in, .user_valid_in, .user_beat_in, .user_ready_out, .busy_out,
      .beat_count_out, .packet_error_out, .ready_in, .valid_out, .data_out, .channel_out, .error_out,
      .startofpacket_out, .endofpacket_out, .empty_out);
   stream_sink_model snk (.core_clk_in, .rst_n_in, .mode_in(mode), .beat_in(sb), .ready_out(ready_in));
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("counts: checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic stream_pkg::user_beat_t mk(logic [31:0] d, logic [7:0] c, logic [1:0] r, logic s, logic p,
      logic [1:0] m);
      return {d, c, r, s, p, m};
   endfunction
   // hold the offer until the controller takes it
   task automatic send(input stream_pkg::user_beat_t b);
      int i;
      @(negedge core_clk_in);
      user_valid_in = 1'b1;
      user_beat_in = b;
      i = 0;
      // ready is a flop, so its level at the falling edge is what the next rising edge takes
      while (user_ready_out !== 1'b1 && i < 50)
      begin
         @(negedge core_clk_in);
         i++;
      end
      if (i >= 50)
         check("user_ready_out", user_ready_out, 1'b1);
      @(posedge core_clk_in);
   endtask
   task automatic do_reset;
      @(negedge core_clk_in);
      rst_n_in = 1'b0;
      user_valid_in = 1'b0;
      repeat (8) @(negedge core_clk_in);
      check("reset stream", sb, 64'h0);
      check("reset user_ready_out", user_ready_out, 1'b0);
      rst_n_in = 1'b1;
      repeat (2) @(negedge core_clk_in);
   endtask
   // send n beats under a backpressure mode, optionally stalled first
   task automatic run(input int n, input logic [1:0] m, input int hold);
      logic [15:0] c0;
      stream_pkg::user_beat_t x;
      int i;
      snk.got.delete();
      c0 = beat_count_out;
      @(negedge core_clk_in);
      mode = m;
      for (i = 0; i < n; i++)
         send(e[i]);
      @(negedge core_clk_in);
      user_valid_in = 1'b0;
      if (hold > 0)
      begin
         repeat (hold) @(negedge core_clk_in);
         check("held beats", snk.got.size(), 0);
         check("held out", {valid_out, data_out}, {1'b1, e[0].data});
         check("busy_out", busy_out, 1'b1);
         mode = 2'h2;
      end
      i = 0;
      while (snk.got.size() < n && i < 40)
      begin
         @(negedge core_clk_in);
         i++;
      end
      check("beats", snk.got.size(), n);
      check("busy_out idle", busy_out, 1'b0);
      check("user_ready_out idle", user_ready_out, 1'b1);
      for (i = 0; i < n && i < snk.got.size(); i++)
      begin
         x = e[i];
         if (!x.endofpacket)
            x.empty = '0;
         check("beat", snk.got[i], {1'b1, x});
      end
      check("beat_count_out", beat_count_out, c0 + 16'(n));
   endtask
   initial
   begin
      do_reset();
      e[0] = mk(32'hA0A1A2A3, 8'h00, 2'h0, 1'b1, 1'b0, 2'h0);
      e[1] = mk(32'hB0B1B2B3, 8'h7F, 2'h1, 1'b0, 1'b0, 2'h2);
      e[2] = mk(32'hC0C1C2C3, 8'hFE, 2'h2, 1'b0, 1'b0, 2'h0);
      e[3] = mk(32'hD0000000, 8'hFF, 2'h3, 1'b0, 1'b1, 2'h3);
      run(4, 2'h0, 0);
      check("no fault", packet_error_out, 1'b0);
      $display("test packet done");
      run(2, 2'h1, 5);
      $display("test stall done");
      e[1] = e[0];
      run(2, 2'h0, 0);
      check("start in packet", packet_error_out, 1'b1);
      do_reset();
      e[0] = e[3];
      run(1, 2'h0, 0);
      check("end outside packet", packet_error_out, 1'b1);
      $display("test framing done");
      report_and_stop();
   end
   // cut a hang short well past the expected run length
   initial
   begin
      #120000;
      n_fail++;
      report_and_stop();
   end
endmodule // stream_source_bench
